// ===== verilog/sink_driver.sv
// Serial-in, latched, eight-channel open-drain sink driver.
// Assumes host pins are asynchronous to i_clk and slower than a few clock periods.
//
// How it works
// - Eight-stage shift register feeds eight-bit storage
// - Shift clock rise shifts serial input in
// - Latch clock rise copies shift register
// - Clear low zeroes shift, storage untouched
// - Enable high forces all sink bits off
// - Enable low passes storage bits straight through
// - Cascade output allows chaining further devices
// - Sink bit one pulls drain low
// - Eight independent switched outputs, one per bit
`default_nettype none
module sink_driver (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_serial_input,
    input wire logic i_shift_clk,
    input wire logic i_latch_clk,
    input wire logic i_shift_clear_n,
    input wire logic i_output_enable_n,
    output logic o_cascade_output,
    output logic [sink_driver_pkg::STAGES-1:0] o_sink_out,
    output logic [sink_driver_pkg::STAGES-1:0] o_sink_oe,
    output logic o_latch_overrun,
    output var sink_driver_pkg::fill_t o_fill_state
);
    import sink_driver_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] sync_data, sync_sclk, sync_lclk, sync_clr, sync_oe;
    logic sclk_prev, lclk_prev;
    logic sclk_rise, lclk_rise;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync_data <= SYNC_RESET;
            sync_sclk <= SYNC_RESET;
            sync_lclk <= SYNC_RESET;
            sync_clr <= SYNC_RESET;
            sync_oe <= 2'h3;
            sclk_prev <= 1'b0;
            lclk_prev <= 1'b0;
        end else begin
            sync_data <= {sync_data[0], i_serial_input};
            sync_sclk <= {sync_sclk[0], i_shift_clk};
            sync_lclk <= {sync_lclk[0], i_latch_clk};
            sync_clr <= {sync_clr[0], i_shift_clear_n};
            sync_oe <= {sync_oe[0], i_output_enable_n};
            sclk_prev <= sync_sclk[1];
            lclk_prev <= sync_lclk[1];
        end
    end

    // Edges found only on synchronised copies; data lags the clock by the same two stages
    assign sclk_rise = sync_sclk[1] && !sclk_prev;
    assign lclk_rise = sync_lclk[1] && !lclk_prev;

    // ----------------------------------------
    // Shift and storage registers
    // ----------------------------------------
    byte_t shift_reg, next_shift_reg;
    byte_t store_reg, next_store_reg;
    logic cascade, next_cascade;
    logic [3:0] shift_count, next_shift_count;
    fill_t fill, next_fill;
    logic overrun, next_overrun;
    word_stream_if latch_in ();
    word_stream_if latch_out ();

    always_comb begin
        next_shift_reg = shift_reg;
        next_shift_count = shift_count;
        if (!sync_clr[1]) begin
            next_shift_reg = SHIFT_RESET;
            next_shift_count = '0;
        end else if (sclk_rise) begin
            next_shift_reg = {shift_reg[STAGES-2:0], sync_data[1]};
            if (shift_count != 4'(STAGES)) begin
                next_shift_count = shift_count + 4'h1;
            end
        end
        if (lclk_rise) begin
            next_shift_count = '0;
        end
        // Cascade shows the last stage as it stands after each shift or clear
        next_cascade = next_shift_reg[STAGES-1];
        // Progress of the host's eight-shift-then-latch sequence
        case (next_shift_count)
            4'h0: next_fill = ST_IDLE;
            4'(STAGES): next_fill = ST_FULL;
            default: next_fill = ST_SHIFTING;
        endcase
    end

    // The latch edge pushes a snapshot; clear does not disturb what is queued or stored
    assign latch_in.valid = lclk_rise;
    assign latch_in.data = shift_reg;
    // A latch lost to a full queue is flagged rather than silently dropped
    assign next_overrun = overrun || (lclk_rise && !latch_in.ready);

    word_fifo #(
        .WIDTH(STAGES),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .wr(latch_in),
        .rd(latch_out)
    );

    // Storage accepts one word per cycle; kept steady between latches
    assign latch_out.ready = 1'b1;
    always_comb begin
        next_store_reg = latch_out.valid ? latch_out.data : store_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            shift_reg <= SHIFT_RESET;
            store_reg <= STORE_RESET;
            cascade <= 1'b0;
            shift_count <= '0;
            fill <= ST_IDLE;
            overrun <= 1'b0;
        end else begin
            shift_reg <= next_shift_reg;
            store_reg <= next_store_reg;
            cascade <= next_cascade;
            shift_count <= next_shift_count;
            fill <= next_fill;
            overrun <= next_overrun;
        end
    end

    // ----------------------------------------
    // Output buffer and open-drain pins
    // ----------------------------------------
    byte_t buffer_bits, next_buffer_bits;
    always_comb begin
        // Enable high blanks everything; low is transparent with one register of delay
        next_buffer_bits = sync_oe[1] ? SINK_OFF : store_reg;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            buffer_bits <= SINK_OFF;
        end else begin
            buffer_bits <= next_buffer_bits;
        end
    end

    // Each channel drives low only while its bit is one
    genvar ch;
    generate
        for (ch = 0; ch < STAGES; ch++) begin : g_sink
            assign o_sink_out[ch] = 1'b0;
            assign o_sink_oe[ch] = buffer_bits[ch];
        end
    endgenerate

    assign o_cascade_output = cascade;
    assign o_latch_overrun = overrun;
    assign o_fill_state = fill;
endmodule
`default_nettype wire

// ===== verilog/sink_driver_pkg.sv
// Constants and types shared by the serial-in latched sink driver.
// Assumes one 250 MHz system clock that samples all host pins.
`default_nettype none
package sink_driver_pkg;
    localparam int STAGES = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [7:0] STORE_RESET = 8'h00;
    localparam logic [7:0] SINK_OFF = 8'h00;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    typedef logic [STAGES-1:0] byte_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFTING = 2'b01,
        ST_FULL = 2'b11
    } fill_t;
endpackage
`default_nettype wire

// ===== verilog/word_stream_if.sv
// Valid/ready stream carrying latched words between the latch stage and the output stage.
// Assumes both ends share i_clk.
`default_nettype none
interface word_stream_if;
    import sink_driver_pkg::*;
    logic valid;
    logic ready;
    byte_t data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== verilog/word_fifo.sv
// Parameterised FIFO with valid/ready on both sides and a registered read word.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    word_stream_if.sink wr,
    word_stream_if.source rd
);
    // ----------------------------------------
    // Storage and pointers
    // ----------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [WIDTH-1:0] out_data, next_out_data;
    logic out_valid, next_out_valid;
    logic mem_empty, mem_full, do_write, do_read;

    assign mem_empty = (wr_ptr == rd_ptr);
    assign mem_full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign wr.ready = !mem_full;
    assign do_write = wr.valid && !mem_full;
    // Output register refills when empty or being drained
    assign do_read = !mem_empty && (!out_valid || rd.ready);
    assign rd.valid = out_valid;
    assign rd.data = out_data;

    always_comb begin
        next_wr_ptr = do_write ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_read ? rd_ptr + 1'b1 : rd_ptr;
        next_out_data = do_read ? mem[rd_ptr[AW-1:0]] : out_data;
        next_out_valid = do_read ? 1'b1 : (rd.ready ? 1'b0 : out_valid);
    end

    always_ff @(posedge i_clk) begin
        if (do_write) begin
            mem[wr_ptr[AW-1:0]] <= wr.data;
        end
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            out_data <= '0;
            out_valid <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            out_data <= next_out_data;
            out_valid <= next_out_valid;
        end
    end
endmodule
`default_nettype wire

// ===== tb/sink_driver_monitor.sv
// Port checker for the sink driver.
// Assumes host pins change only just after clock edges.
`default_nettype none
module sink_driver_monitor (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_shift_clk,
    input wire logic i_latch_clk,
    input wire logic i_shift_clear_n,
    input wire logic i_output_enable_n,
    input wire logic o_cascade_output,
    input wire logic [7:0] o_sink_out,
    input wire logic [7:0] o_sink_oe,
    input wire logic o_latch_overrun
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] since_shift;
    logic [3:0] since_out;
    // ------------------------------
    // Cycles since last cause
    // ------------------------------
    always_ff @(posedge i_clk) begin
        since_shift <= i_rst ? 4'hf : $rose(i_shift_clk) ? 4'h0 : since_shift + {3'h0, since_shift != 4'hf};
        since_out <= i_rst ? 4'hf : ($rose(i_latch_clk) || $changed(i_output_enable_n)) ? 4'h0
            : since_out + {3'h0, since_out != 4'hf};
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sink_out_zero_a: assert property (o_sink_out == 8'h00) else $error("sink value not zero");
    oe_off_a: assert property (i_output_enable_n [*4] |-> o_sink_oe == 8'h00) else $error("sink on while off");
    clear_zero_a: assert property (!i_shift_clear_n [*5] |-> !o_cascade_output) else $error("clear ignored");
    cascade_hold_a: assert property (($stable(i_shift_clk) && i_shift_clear_n) [*6] |-> $stable(o_cascade_output))
        else $error("cascade moved without shift");
    oe_hold_a: assert property (($stable(i_latch_clk) && $stable(i_output_enable_n)) [*8] ##1 1 |-> $stable(o_sink_oe))
        else $error("sink moved without cause");
    cascade_cause_a: assert property ($rose(o_cascade_output) |-> since_shift inside {[1:6]})
        else $error("cascade rose off shift");
    oe_cause_a: assert property ($changed(o_sink_oe) |-> since_out <= 4'hc) else $error("late sink change");
    no_overrun_a: assert property (!o_latch_overrun) else $error("latch dropped");
endmodule
bind sink_driver sink_driver_monitor i_sink_driver_monitor (.i_clk(i_clk), .i_rst(i_rst),
    .i_shift_clk(i_shift_clk), .i_latch_clk(i_latch_clk), .i_shift_clear_n(i_shift_clear_n),
    .i_output_enable_n(i_output_enable_n), .o_cascade_output(o_cascade_output),
    .o_sink_out(o_sink_out), .o_sink_oe(o_sink_oe), .o_latch_overrun(o_latch_overrun));
`default_nettype wire

// ===== tb/host_model.sv
// Host controller model driving the pins at a 48 ns link period.
// Assumes a 4 ns i_clk; pins change just after its rising edges.
`default_nettype none
module host_model (
    input wire logic i_clk,
    output logic o_serial_input,
    output logic o_shift_clk,
    output logic o_latch_clk,
    output logic o_shift_clear_n,
    output logic o_output_enable_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_serial_input, o_shift_clk, o_latch_clk} = 3'h0;
        {o_shift_clear_n, o_output_enable_n} = 2'h3;
    end
    // Data moves with the falling clock, so it is held across the rise
    task automatic shift_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            o_serial_input <= b[i];
            repeat (6) @(posedge i_clk);
            o_shift_clk <= 1'b1;
            repeat (6) @(posedge i_clk);
            o_shift_clk <= 1'b0;
        end
    endtask
    task automatic latch();
        repeat (6) @(posedge i_clk);
        o_latch_clk <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_latch_clk <= 1'b0;
    endtask
    task automatic set_pins(input logic en_n, input logic clr_n);
        o_output_enable_n <= en_n;
        o_shift_clear_n <= clr_n;
        repeat (12) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the sink driver.
// Assumes the host model and the bound port checker.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sink_driver_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    wire logic ser, sclk, lclk, clr_n, en_n;
    logic cascade, overrun;
    logic [7:0] sink_out, sink_oe;
    fill_t fill;
    int mismatches = 0;
    int n_checks = 0;
    initial forever #2 i_clk = ~i_clk;
    sink_driver i_sink_driver (.i_clk(i_clk), .i_rst(i_rst), .i_serial_input(ser), .i_shift_clk(sclk),
        .i_latch_clk(lclk), .i_shift_clear_n(clr_n), .i_output_enable_n(en_n), .o_cascade_output(cascade),
        .o_sink_out(sink_out), .o_sink_oe(sink_oe), .o_latch_overrun(overrun), .o_fill_state(fill));
    host_model i_host_model (.i_clk(i_clk), .o_serial_input(ser), .o_shift_clk(sclk), .o_latch_clk(lclk),
        .o_shift_clear_n(clr_n), .o_output_enable_n(en_n));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Settled sampling, away from the edge
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic t_load();
        i_host_model.set_pins(1'b0, 1'b1);
        i_host_model.shift_byte(8'ha5);
        settle(8);
        check({7'h00, cascade}, 8'h01);
        check({6'h00, fill}, {6'h00, ST_FULL});
        i_host_model.latch();
        settle(20);
        check({6'h00, fill}, {6'h00, ST_IDLE});
        check(sink_oe, 8'ha5);
        check(sink_out, 8'h00);
    endtask
    task automatic t_enable();
        i_host_model.set_pins(1'b1, 1'b1);
        check(sink_oe, 8'h00);
        i_host_model.set_pins(1'b0, 1'b1);
        check(sink_oe, 8'ha5);
    endtask
    task automatic t_clear();
        i_host_model.shift_byte(8'hc3);
        i_host_model.set_pins(1'b0, 1'b0);
        check({7'h00, cascade}, 8'h00);
        check({6'h00, fill}, {6'h00, ST_IDLE});
        check(sink_oe, 8'ha5);
        i_host_model.set_pins(1'b0, 1'b1);
        i_host_model.latch();
        settle(20);
        check(sink_oe, 8'h00);
    endtask
    task automatic t_chain();
        i_host_model.shift_byte(8'h5a);
        check({7'h00, cascade}, 8'h00);
        check({6'h00, fill}, {6'h00, ST_FULL});
        i_host_model.shift_byte(8'h81);
        i_host_model.latch();
        settle(20);
        check(sink_oe, 8'h81);
        check({7'h00, cascade}, 8'h01);
        check({7'h00, overrun}, 8'h00);
    endtask
    task automatic summarize();
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_load();
        t_enable();
        t_clear();
        t_chain();
        summarize();
    end
    // Whole run needs about 550 cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
